//--- shared/wpf_cfg.svh
// Constants for the write-port flag control block.
`ifndef WPF_CFG_SVH
`define WPF_CFG_SVH
`define WPF_ADDR_W 8
`define WPF_DEV_ID_W 3
`define WPF_QUEUE_W 5
`define WPF_WORD_W 8
`define WPF_NUM_WORDS 4
`define WPF_WORD_SEL_W 2
`define WPF_FLAG_DELAY 3
`define WPF_NUM_QUEUES 32
`define WPF_MODE_POLLED 1'b1
`endif

//--- shared/wpf_pkg.sv
// Types shared by both ends of the write-port flag link.
`include "wpf_cfg.svh"
package wpf_pkg;
  typedef logic [`WPF_ADDR_W-1:0] wpf_addr_t;
  typedef logic [`WPF_WORD_W-1:0] wpf_word_t;
  typedef logic [`WPF_DEV_ID_W-1:0] wpf_dev_t;
  typedef enum logic [1:0] {
    WPF_SEL_IDLE = 2'b00,
    WPF_SEL_WAIT = 2'b01,
    WPF_SEL_LIVE = 2'b11
  } wpf_sel_e;
endpackage : wpf_pkg

//--- shared/wpf_if.sv
// Interface joining the writer and the flag control device.
`timescale 1ns/100ps
interface wpf_if;
  import wpf_pkg::*;
  wpf_addr_t write_queue_select_bus;
  logic write_select_enable;
  logic write_en;
  logic flag_bus_mode_select;
  logic almost_full_bus_strobe;
  logic queue_full_flag_o;
  logic queue_full_flag_oe_n;
  wpf_word_t almost_full_status_bus;
  logic almost_full_sync_pulse;
  logic serial_program_done;
  modport device (
    input write_queue_select_bus, write_select_enable, write_en, flag_bus_mode_select,
    input almost_full_bus_strobe,
    output queue_full_flag_o, queue_full_flag_oe_n, almost_full_status_bus,
    output almost_full_sync_pulse, serial_program_done
  );
  modport host (
    output write_queue_select_bus, write_select_enable, write_en, flag_bus_mode_select,
    output almost_full_bus_strobe,
    input queue_full_flag_o, queue_full_flag_oe_n, almost_full_status_bus,
    input almost_full_sync_pulse, serial_program_done
  );
endinterface : wpf_if

//--- rtl/wpf_device.sv
// Device end: full flag per selected write queue and almost-full status bus.
//
// Overview of operation
// - Drive full flag of selected write queue.
// - Flag shows new queue from third cycle.
// - Writer writes next cycle only if flag high.
// - Full flag tristates; eight devices share it.
// - Only selected device drives shared flag line.
// - Flag leaves high impedance next cycle.
// - Full flag changes only on write clock.
// - Latch mode at reset: high polled.
// - Mode input stable from before reset.
// - Direct: strobe selects addressed status word.
// - Polled mode: strobe held low.
// - Strobe only after programming done low.
// - Polled: cycle four words, wrap on fifth.
// - Sync high while first word shown.
`timescale 1ns/100ps
`include "wpf_cfg.svh"
module wpf_device #(
  parameter logic [`WPF_DEV_ID_W-1:0] DEV_ID = 3'h0
) (
  input wire logic ref_clk,
  input wire logic rst,
  wpf_if.device link,
  input wire logic prog_done,
  input wire logic [`WPF_NUM_QUEUES-1:0] queue_full,
  input wire logic [`WPF_NUM_QUEUES-1:0] queue_almost_full,
  output logic write_accept,
  output logic [`WPF_QUEUE_W-1:0] write_queue
);
  import wpf_pkg::*;

  // Selection timing, seen from the write port:
  //   cycle 0: the writer raises write_select_enable with device and queue on the bus.
  //   cycle 1: the owning device starts to drive the flag line, still held low.
  //   cycle 2: the flag is still held low while the new queue's status is fetched.
  //   cycle 3: the flag shows whether the selected queue can take another word.
  // Holding the flag low while it settles costs two write cycles on every change of
  // queue, but a writer that trusts the flag can never write into a full queue.
  // The upper select bits name the device, so only one device on a shared flag line
  // takes ownership, and every other device lets go of the line on the same edge.

  // Mode and programming state.
  logic mode_reg;
  logic mode_next;
  logic prog_reg;
  logic prog_next;

  // Selection state and the full flag.
  wpf_sel_e sel_reg;
  wpf_sel_e sel_next;
  logic [1:0] dly_reg;
  logic [1:0] dly_next;
  logic own_reg;
  logic own_next;
  logic [`WPF_QUEUE_W-1:0] q_reg;
  logic [`WPF_QUEUE_W-1:0] q_next;
  logic ff_reg;
  logic ff_next;
  logic sel_hit;

  // Almost-full status bus state.
  logic [`WPF_WORD_SEL_W-1:0] word_reg;
  logic [`WPF_WORD_SEL_W-1:0] word_next;
  wpf_word_t bus_reg;
  wpf_word_t bus_next;
  logic sync_reg;
  logic sync_next;
  logic [`WPF_WORD_SEL_W-1:0] load_word;
  wpf_word_t status_word [`WPF_NUM_WORDS];

  // The device owns the flag line when the upper select bits carry its identity.
  assign sel_hit = link.write_queue_select_bus[`WPF_ADDR_W-1 -: `WPF_DEV_ID_W] == DEV_ID;

  // The mode stays as latched at reset; programming done is sticky once seen.
  always_comb begin
    mode_next = mode_reg;
    prog_next = prog_reg | prog_done;
  end

  // The mode is caught by the clock while reset is held, so the pin must settle first.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_reg <= link.flag_bus_mode_select;
      prog_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      prog_reg <= prog_next;
    end
  end

  // Selection tracking and the full flag; the flag is forced low while the new queue settles.
  always_comb begin
    sel_next = sel_reg;
    dly_next = dly_reg;
    own_next = own_reg;
    q_next = q_reg;
    ff_next = ff_reg;
    if (link.write_select_enable) begin
      own_next = sel_hit;
      q_next = link.write_queue_select_bus[`WPF_QUEUE_W-1:0];
      sel_next = WPF_SEL_WAIT;
      dly_next = 2'(`WPF_FLAG_DELAY - 2);
      ff_next = 1'b0; // Safe until the new status arrives.
    end else begin
      case (sel_reg)
        WPF_SEL_IDLE: begin
          ff_next = 1'b0; // Nothing selected yet, so nothing may be written.
        end
        WPF_SEL_WAIT: begin
          // Count down the settling cycles before the status is shown.
          if (dly_reg == 2'h0) begin
            sel_next = WPF_SEL_LIVE;
            ff_next = ~queue_full[q_reg];
          end else begin
            dly_next = dly_reg - 2'h1;
          end
        end
        WPF_SEL_LIVE: begin
          // Follow the queue while it stays selected, so a full queue drops the flag.
          ff_next = ~queue_full[q_reg];
        end
        default: begin
          ff_next = 1'b0;
        end
      endcase
    end
  end

  // Selection registers; after reset no device drives the flag line, and the flag
  // reads as full until a queue is selected.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sel_reg <= WPF_SEL_IDLE;
      dly_reg <= 2'h0;
      own_reg <= 1'b0;
      q_reg <= 5'h00;
      ff_reg <= 1'b0;
    end else begin
      sel_reg <= sel_next;
      dly_reg <= dly_next;
      own_reg <= own_next;
      q_reg <= q_next;
      ff_reg <= ff_next;
    end
  end

  // Status word k carries the almost-full bits of queues 8k to 8k+7.
  for (genvar k = 0; k < `WPF_NUM_WORDS; k++) begin : g_word
    assign status_word[k] = queue_almost_full[k*`WPF_WORD_W +: `WPF_WORD_W];
  end

  // Polled timing: the first edge after reset loads word 0 with the sync output high,
  // the next three edges load words 1 to 3 with sync low, and the fifth edge loads
  // word 0 again. In direct mode the bus keeps the last word that a strobe selected,
  // and the sync output stays low.
  // Limitation: the bus shows the almost-full inputs one edge late, and in direct mode
  // a word is not refreshed until the next strobe.
  // Almost-full status bus: polled rotation or strobe-addressed word.
  // A strobe that comes before programming has finished is dropped, so no word of
  // unprogrammed queues can be latched onto the bus in direct mode.
  always_comb begin
    word_next = word_reg;
    bus_next = bus_reg;
    sync_next = 1'b0;
    load_word = word_reg;
    if (mode_reg == `WPF_MODE_POLLED) begin
      // Polled: one word per edge, wrapping after the last word.
      word_next = word_reg + 2'h1;
      bus_next = status_word[load_word];
      sync_next = (load_word == 2'h0);
    end else if (link.almost_full_bus_strobe && prog_reg) begin
      // Direct: the strobe latches the word addressed by the low select bits.
      load_word = link.write_queue_select_bus[`WPF_WORD_SEL_W-1:0];
      bus_next = status_word[load_word];
    end
  end

  // Status bus registers.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      word_reg <= 2'h0;
      bus_reg <= 8'h00;
      sync_reg <= 1'b0;
    end else begin
      word_reg <= word_next;
      bus_reg <= bus_next;
      sync_reg <= sync_next;
    end
  end

  // Flag line drive; the output enable is low only while this device owns the line.
  assign link.queue_full_flag_o = ff_reg;
  assign link.queue_full_flag_oe_n = ~own_reg;

  // Status outputs come straight from their registers.
  assign link.almost_full_status_bus = bus_reg;
  assign link.almost_full_sync_pulse = sync_reg;

  // Programming done is shown active low, as the writer expects.
  assign link.serial_program_done = ~prog_reg;

  // Writes are dropped while the flag is low, guarding queues from a careless writer.
  assign write_accept = link.write_en & ff_reg & own_reg;
  assign write_queue = q_reg;
endmodule : wpf_device

//--- rtl/wpf_host.sv
// Host end: selects write queues, writes when allowed and drives the strobe.
`timescale 1ns/100ps
`include "wpf_cfg.svh"
module wpf_host (
  input wire logic ref_clk,
  input wire logic rst,
  wpf_if.host link,
  input wire logic polled_mode,
  input wire logic sel_req,
  input wire wpf_pkg::wpf_addr_t sel_addr,
  input wire logic wr_req,
  input wire logic strobe_req,
  output logic wr_done,
  output logic full_seen
);
  import wpf_pkg::*;

  logic mode_reg, mode_next;
  wpf_addr_t addr_reg, addr_next;
  logic sel_reg, sel_next;
  logic wr_reg, wr_next;
  logic stb_reg, stb_next;
  logic flag_high;

  // Only a driven high flag counts; a floating line must not permit writes.
  assign flag_high = ~link.queue_full_flag_oe_n & link.queue_full_flag_o;

  // Mode is fixed during reset; strobe waits for programming done.
  always_comb begin
    mode_next = mode_reg;
    // The strobe addresses its status word over the select bus as well.
    addr_next = (sel_req | strobe_req) ? sel_addr : addr_reg;
    sel_next = sel_req;
    // A select already on its way to the device drops the flag at the next edge.
    wr_next = wr_req & flag_high & ~sel_req & ~sel_reg;
    stb_next = strobe_req & ~mode_reg & ~link.serial_program_done;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_reg <= polled_mode;
      addr_reg <= 8'h00;
      sel_reg <= 1'b0;
      wr_reg <= 1'b0;
      stb_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      addr_reg <= addr_next;
      sel_reg <= sel_next;
      wr_reg <= wr_next;
      stb_reg <= stb_next;
    end
  end

  // The mode pin follows the user input only while reset holds, then freezes.
  assign link.flag_bus_mode_select = rst ? polled_mode : mode_reg;
  assign link.write_queue_select_bus = addr_reg;
  assign link.write_select_enable = sel_reg;
  assign link.write_en = wr_reg;
  assign link.almost_full_bus_strobe = stb_reg;
  assign wr_done = wr_reg;
  assign full_seen = ~link.queue_full_flag_oe_n & ~link.queue_full_flag_o;
endmodule : wpf_host

//--- bench/wpf_properties.sv
// Concurrent checks on the link between writer and flag device.
`timescale 1ns/100ps
module wpf_properties #(parameter logic [2:0] DEV_ID = 3'h0) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire wpf_pkg::wpf_addr_t write_queue_select_bus,
  input wire logic write_select_enable,
  input wire logic write_en,
  input wire logic flag_bus_mode_select,
  input wire logic almost_full_bus_strobe,
  input wire logic queue_full_flag_o,
  input wire logic queue_full_flag_oe_n,
  input wire logic almost_full_sync_pulse,
  input wire logic serial_program_done
);
  import wpf_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // The flag is held low until the new status is valid, so no write slips in early.
  sequence s_settle; !queue_full_flag_o [*2]; endsequence
  sequence s_gap; !almost_full_sync_pulse [*3] ##1 almost_full_sync_pulse; endsequence
  wire own = write_select_enable && (write_queue_select_bus[7:5] == DEV_ID);
  AST_OE_ON: assert property (own |=> !queue_full_flag_oe_n) else $error("flag not driven");
  AST_OE_OFF: assert property (write_select_enable && !own |=> queue_full_flag_oe_n)
    else $error("foreign flag driven");
  AST_SETTLE: assert property (own |=> s_settle) else $error("flag early");
  AST_OE_HOLD: assert property (!write_select_enable |=> $stable(queue_full_flag_oe_n))
    else $error("drive changed");
  AST_POLL: assert property (flag_bus_mode_select && almost_full_sync_pulse |=> s_gap)
    else $error("poll order");
  AST_STR_POLL: assert property (flag_bus_mode_select |-> !almost_full_bus_strobe)
    else $error("strobe in polled mode");
  AST_STR_PROG: assert property (almost_full_bus_strobe |-> !serial_program_done)
    else $error("strobe too early");
  AST_MODE_HOLD: assert property ($stable(flag_bus_mode_select))
    else $error("mode pin moved");
  AST_WR_FLAG: assert property (write_en |-> queue_full_flag_o && !queue_full_flag_oe_n)
    else $error("write while full");
endmodule : wpf_properties

//--- bench/testbench.sv
// Self-checking bench joining host and device ends.
`timescale 1ns/100ps
module testbench;
  import wpf_pkg::*;
  logic ref_clk = 0, rst = 1, polled_mode = 0, sel_req = 0, wr_req = 0, strobe_req = 0;
  logic prog_done = 0, write_accept;
  wpf_addr_t sel_addr = 8'h00;
  logic [31:0] queue_full = 32'h0000_0040, queue_almost_full = 32'hA1B2_C3D4;
  logic [4:0] write_queue;
  logic wr_done, full_seen;
  logic [7:0] snap = 8'h00;
  int error_cnt = 0, checks_done = 0;
  wpf_if link ();
  wpf_device #(.DEV_ID(3'h0)) wpf_device_inst (.ref_clk(ref_clk), .rst(rst), .link(link),
    .prog_done(prog_done), .queue_full(queue_full), .queue_almost_full(queue_almost_full),
    .write_accept(write_accept), .write_queue(write_queue));
  wpf_host wpf_host_inst (.ref_clk(ref_clk), .rst(rst), .link(link), .polled_mode(polled_mode),
    .sel_req(sel_req), .sel_addr(sel_addr), .wr_req(wr_req), .strobe_req(strobe_req),
    .wr_done(wr_done), .full_seen(full_seen));
  wpf_properties #(.DEV_ID(3'h0)) wpf_properties_inst (.ref_clk(ref_clk), .rst(rst),
    .write_queue_select_bus(link.write_queue_select_bus),
    .write_select_enable(link.write_select_enable), .write_en(link.write_en),
    .flag_bus_mode_select(link.flag_bus_mode_select),
    .almost_full_bus_strobe(link.almost_full_bus_strobe),
    .queue_full_flag_o(link.queue_full_flag_o), .queue_full_flag_oe_n(link.queue_full_flag_oe_n),
    .almost_full_sync_pulse(link.almost_full_sync_pulse),
    .serial_program_done(link.serial_program_done));
  // Free-running write clock.
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  // One-cycle request (kind 0 select, 1 write, 2 strobe); returns at the edge where the
  // link takes it, with strobe, write done and write accept captured while they stand.
  task automatic req(input int kind, input wpf_addr_t a);
    snap = 8'h00;
    fork
      begin
        @(posedge ref_clk);
        sel_addr <= a;
        sel_req <= (kind == 0);
        wr_req <= (kind == 1);
        strobe_req <= (kind == 2);
        @(posedge ref_clk);
        sel_req <= 1'b0;
        wr_req <= 1'b0;
        strobe_req <= 1'b0;
      end
      begin
        for (int n = 0; n < 20; n++) begin
          @(negedge ref_clk);
          if ((kind == 0 && link.write_select_enable === 1'b1) ||
              (kind == 1 && link.write_en === 1'b1) ||
              (kind == 2 && link.almost_full_bus_strobe === 1'b1)) begin
            snap = 8'({link.almost_full_bus_strobe, wr_done, write_accept});
            break;
          end
        end
        @(posedge ref_clk);
      end
    join
  endtask : req
  // Select a queue, then check drive and settling flag, and the settled flag, at falling edges.
  task automatic sel_q(input wpf_addr_t a, input logic oe_n, input logic flag);
    req(0, a);
    @(negedge ref_clk);
    chk(8'(link.queue_full_flag_oe_n), 8'(oe_n));
    if (!oe_n) begin
      chk(8'(link.queue_full_flag_o), 8'h00);
    end
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    if (!oe_n) begin
      chk(8'(link.queue_full_flag_o), 8'(flag));
      chk(8'(write_queue), 8'(a[4:0]));
    end
  endtask : sel_q
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim
  // Main sequence: direct mode first, then a second reset into polled mode.
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    sel_q(8'h05, 1'b0, 1'b1);
    chk(8'(full_seen), 8'h00);
    req(1, 8'h05);
    chk(snap, 8'h03);
    sel_q(8'h06, 1'b0, 1'b0);
    chk(8'(full_seen), 8'h01);
    req(1, 8'h06);
    chk(snap, 8'h00);
    @(negedge ref_clk);
    chk(8'(link.write_en), 8'h00);
    sel_q(8'h25, 1'b1, 1'b0);
    $display("Select tests done");
    req(2, 8'h01);
    chk(snap, 8'h00);
    @(negedge ref_clk);
    chk(link.almost_full_status_bus, 8'h00);
    @(posedge ref_clk);
    prog_done <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      req(2, 8'(k));
      chk(snap, 8'h04);
      @(negedge ref_clk);
      chk(link.almost_full_status_bus, queue_almost_full[8*k+:8]);
    end
    $display("Strobe tests done");
    @(posedge ref_clk);
    rst <= 1'b1;
    polled_mode <= 1'b1;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    for (int n = 0; n < 20 && link.almost_full_sync_pulse !== 1'b1; n++) @(negedge ref_clk);
    for (int i = 0; i < 5; i++) begin
      chk(link.almost_full_status_bus, queue_almost_full[8*(i%4)+:8]);
      chk(8'(link.almost_full_sync_pulse), 8'(i % 4 == 0));
      @(negedge ref_clk);
    end
    req(2, 8'h01);
    chk(snap, 8'h00);
    $display("Mode tests done");
    end_sim;
  end
  // Watchdog sized well beyond the hundred or so cycles the tests take.
  initial begin
    repeat (2000) @(posedge ref_clk);
    error_cnt++;
    end_sim;
  end
endmodule : testbench
